/* File: verilog/rlrc_defines.vh */
/*
 * rlrc_defines.vh - constants for the restart limit and run counter block:
 * register offsets, reset values, error codes, phase codes and timing counts.
 * Assumes inclusion by its bare name from the design file.
 */
`ifndef RLRC_DEFINES_VH
`define RLRC_DEFINES_VH

// ----------------------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------------------
`define RLRC_REG_CTRL 4'h0
`define RLRC_REG_STAT 4'h1
`define RLRC_REG_SP_LIMIT 4'h2
`define RLRC_REG_LOWFIRE_MAX 4'h3
`define RLRC_REG_OPH_RO 4'h4
`define RLRC_REG_OPH_ADJ 4'h5
`define RLRC_REG_LIVE_H 4'h6
`define RLRC_REG_STARTS_RO 4'h7
`define RLRC_REG_STARTS_ADJ 4'h8
`define RLRC_REG_ERROR 4'h9
`define RLRC_REG_COUNTERS 4'hA
`define RLRC_REG_STOP_SEL 4'hB

// ----------------------------------------------------------------------------
// limits and reset values
// ----------------------------------------------------------------------------
`define RLRC_NOFLAME_LIMIT 7'h03
`define RLRC_UNLIMITED 7'h7F
`define RLRC_SP_LIMIT_RST 7'h03
`define RLRC_SL_LIMIT_RST 7'h03
`define RLRC_LOWFIRE_RST 16'h0064

// ----------------------------------------------------------------------------
// error codes (decimal codes as shown to the operator)
// ----------------------------------------------------------------------------
`define RLRC_ERR_NONE 16'h0000
`define RLRC_ERR_NOFLAME_1 16'd1005
`define RLRC_ERR_NOFLAME_2 16'd1067
`define RLRC_ERR_NOFLAME_ELAPSED 16'd1042
`define RLRC_ERR_SP_AIR 16'd1004
`define RLRC_ERR_SP_LIGHT 16'd1009
`define RLRC_ERR_SP_LOOP 16'd1033
`define RLRC_ERR_SP_ELAPSED 16'd1056
`define RLRC_ERR_LOOP_OPEN 16'd1034
`define RLRC_ERR_LOOP_ELAPSED 16'd1057
`define RLRC_ERR_LOWFIRE_TIME 16'd1125

// ----------------------------------------------------------------------------
// program stop phases, selector 0 = deactivated
// ----------------------------------------------------------------------------
`define RLRC_PH_30 8'd30
`define RLRC_PH_34 8'd34
`define RLRC_PH_38 8'd38
`define RLRC_PH_44 8'd44
`define RLRC_PH_52 8'd52
`define RLRC_PH_74 8'd74
`define RLRC_PH_78 8'd78

// ----------------------------------------------------------------------------
// timing: clock rate, one hour, one day, low-fire tick
// ----------------------------------------------------------------------------
`define RLRC_CLK_HZ 100000000
`define RLRC_HOUR_S 3600
`define RLRC_DAY_H 24
`define RLRC_LOWFIRE_TICK_MS 1

`endif

/* File: verilog/rlrc_top.v */
/*
 * rlrc_top.v - restart limit and run counter block for a burner sequencer.
 * Assumes sequencer events are single-cycle pulses on i_mclk and the
 * non-volatile store reloads the counters via the register port at start-up.
 */
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "rlrc_defines.vh"

// Functional notes
// - no flame after both safety times: at most 3 restarts before operating position is reached
// - no-flame counter reloads at operating position, power-up and reset
// - distinct codes: no flame first time, second time, counter elapsed
// - start-prevention limit settable from 0; value 127 means unlimited
// - start-prevention counter reloads on controlled shutdown, power-up, reset
// - start prevention codes for air, light, loop, and counter elapsed
// - safety-loop counter reloads every 24 powered hours, power-up, reset
// - safety loop open reports a code; elapsed counter reports another
// - program stop selector: off, or phase 30, 34, 38, 44, 52, 74, 78
// - program stop holds until operator deactivates it; no timeout
// - halted at program stop is signalled to the display unit
// - heat request gone: drive low fire first, close fuel valves afterwards
// - configurable maximum time to reach low fire bounds that step
// - operating hours kept in non-volatile storage across mains loss
// - operating hours count from first safety time until operation ends
// - three hour counters: read-only total, adjustable total, powered hours
// - startup counter counts every start cycle, aborted ones too, kept
// - two startup totals: read-only and operator settable
// - new restart limit takes effect only after a lockout, manual or from an elapsed counter, then reset
// - lockout: loop relays off, alarm on, held until manual reset
module rlrc_top #(
  parameter HOUR_CYCLES = 64'd360000000000,
  parameter LOWFIRE_TICK_CYCLES = 32'd100000
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_manual_reset,
  input wire i_manual_lockout,
  input wire i_noflame_first,
  input wire i_noflame_second,
  input wire i_operating_reached,
  input wire i_controlled_shutdown,
  input wire i_sp_air,
  input wire i_sp_light,
  input wire i_sp_loop,
  input wire i_loop_open,
  input wire i_start_cycle,
  input wire i_first_safety_time,
  input wire i_operation_end,
  input wire i_heat_request,
  input wire i_low_fire_reached,
  input wire [7:0] i_phase,
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  output reg o_restart,
  output reg o_lockout,
  output reg o_loop_relays_on,
  output reg o_alarm,
  output reg o_prog_stop_hold,
  output reg o_prog_stop_msg,
  output reg o_drive_low_fire,
  output reg o_close_fuel,
  output reg [15:0] o_error_code,
  output reg o_error_valid
);

  // ----------------------------------------------------------------------------
  // low-fire shutdown sequence state codes
  // ----------------------------------------------------------------------------
  localparam [1:0] LF_RUN = 2'd0;
  localparam [1:0] LF_DRIVE = 2'd1;
  localparam [1:0] LF_CLOSE = 2'd2;

  // ----------------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------------
  // selector code to stop phase; zero means deactivated
  function [7:0] stop_phase;
    input [2:0] sel;
    begin
      case (sel)
        3'd1: stop_phase = `RLRC_PH_30;
        3'd2: stop_phase = `RLRC_PH_34;
        3'd3: stop_phase = `RLRC_PH_38;
        3'd4: stop_phase = `RLRC_PH_44;
        3'd5: stop_phase = `RLRC_PH_52;
        3'd6: stop_phase = `RLRC_PH_74;
        3'd7: stop_phase = `RLRC_PH_78;
        default: stop_phase = 8'h00;
      endcase
    end
  endfunction

  // next restart count: decrement unless unlimited or already zero
  function [6:0] dec_cnt;
    input [6:0] cnt;
    begin
      if (cnt == `RLRC_UNLIMITED || cnt == 7'h00) begin
        dec_cnt = cnt;
      end else begin
        dec_cnt = cnt - 7'h01;
      end
    end
  endfunction

  // ----------------------------------------------------------------------------
  // input synchronisers for the pins from the display unit and reset contact
  // ----------------------------------------------------------------------------
  reg [1:0] mrst_sync_q;
  reg [1:0] mlock_sync_q;
  reg mrst_prev_q;
  wire mrst_pulse = mrst_sync_q[1] & ~mrst_prev_q;

  // two flops per pin, then edge detect on the second stage of the reset pin
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mrst_sync_q <= 2'b00;
      mlock_sync_q <= 2'b00;
      mrst_prev_q <= 1'b0;
    end else begin
      mrst_sync_q <= {mrst_sync_q[0], i_manual_reset};
      mlock_sync_q <= {mlock_sync_q[0], i_manual_lockout};
      mrst_prev_q <= mrst_sync_q[1];
    end
  end

  // ----------------------------------------------------------------------------
  // software settings and counters
  // ----------------------------------------------------------------------------
  reg [6:0] sp_limit_q;       // pending start-prevention limit
  reg [6:0] sp_limit_act_q;   // active start-prevention limit
  reg [6:0] sl_limit_q;
  reg [6:0] sl_limit_act_q;
  reg [15:0] lowfire_max_q;   // low-fire limit in ms ticks
  reg [2:0] stop_sel_q;
  reg [6:0] nf_cnt_q;
  reg [6:0] sp_cnt_q;
  reg [6:0] sl_cnt_q;
  reg [31:0] oph_ro_q;
  reg [31:0] oph_adj_q;
  reg [31:0] live_h_q;
  reg [31:0] starts_ro_q;
  reg [31:0] starts_adj_q;
  reg [63:0] hour_tmr_q;
  reg [63:0] run_tmr_q;
  reg [4:0] day_h_q;
  reg running_q;
  reg [31:0] lf_tick_q;
  reg [15:0] lf_ms_q;
  reg [1:0] lf_state_q;
  reg lf_timeout_q;

  wire hour_tick = (hour_tmr_q == HOUR_CYCLES - 64'd1);
  wire day_tick = hour_tick && (day_h_q == 5'd23);
  wire run_hour = running_q && (run_tmr_q == HOUR_CYCLES - 64'd1);
  wire reload_all = mrst_pulse;

  // failure while a counter is at zero elapses it
  wire nf_fail = i_noflame_first | i_noflame_second;
  wire nf_elapsed = nf_fail && (nf_cnt_q == 7'h00);
  wire sp_fail = i_sp_air | i_sp_light | i_sp_loop;
  wire sp_elapsed = sp_fail && (sp_cnt_q == 7'h00) && (sp_limit_act_q != `RLRC_UNLIMITED);
  wire sl_elapsed = i_loop_open && (sl_cnt_q == 7'h00) && (sl_limit_act_q != `RLRC_UNLIMITED);
  wire fail_elapsed = nf_elapsed | sp_elapsed | sl_elapsed;
  wire lockout_d = o_lockout ? ~mrst_pulse : (mlock_sync_q[1] | fail_elapsed);

  // register writes, restart counters, hour and start counters
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp_limit_q <= `RLRC_SP_LIMIT_RST;
      sp_limit_act_q <= `RLRC_SP_LIMIT_RST;
      sl_limit_q <= `RLRC_SL_LIMIT_RST;
      sl_limit_act_q <= `RLRC_SL_LIMIT_RST;
      lowfire_max_q <= `RLRC_LOWFIRE_RST;
      stop_sel_q <= 3'd0;
      nf_cnt_q <= `RLRC_NOFLAME_LIMIT;
      sp_cnt_q <= `RLRC_SP_LIMIT_RST;
      sl_cnt_q <= `RLRC_SL_LIMIT_RST;
      oph_ro_q <= 32'h00000000;
      oph_adj_q <= 32'h00000000;
      live_h_q <= 32'h00000000;
      starts_ro_q <= 32'h00000000;
      starts_adj_q <= 32'h00000000;
      hour_tmr_q <= 64'h0000000000000000;
      run_tmr_q <= 64'h0000000000000000;
      day_h_q <= 5'd0;
      running_q <= 1'b0;
    end else begin
      // settings
      if (i_wr) begin
        case (i_addr)
          `RLRC_REG_SP_LIMIT: begin
            sp_limit_q <= i_wdata[6:0];
            sl_limit_q <= i_wdata[14:8];
          end
          `RLRC_REG_LOWFIRE_MAX: lowfire_max_q <= i_wdata[15:0];
          `RLRC_REG_STOP_SEL: stop_sel_q <= i_wdata[2:0];
          `RLRC_REG_OPH_RO: oph_ro_q <= i_wdata;
          `RLRC_REG_OPH_ADJ: oph_adj_q <= i_wdata;
          `RLRC_REG_LIVE_H: live_h_q <= i_wdata;
          `RLRC_REG_STARTS_RO: starts_ro_q <= i_wdata;
          `RLRC_REG_STARTS_ADJ: starts_adj_q <= i_wdata;
          default: ;
        endcase
      end
      // pending limits are adopted only on reset out of lockout
      if (o_lockout && mrst_pulse) begin
        sp_limit_act_q <= sp_limit_q;
        sl_limit_act_q <= sl_limit_q;
      end
      // no-flame counter
      if (reload_all || i_operating_reached) begin
        nf_cnt_q <= `RLRC_NOFLAME_LIMIT;
      end else if (nf_fail) begin
        nf_cnt_q <= dec_cnt(nf_cnt_q);
      end
      // start-prevention counter
      if (reload_all || i_controlled_shutdown) begin
        sp_cnt_q <= (o_lockout && mrst_pulse) ? sp_limit_q : sp_limit_act_q;
      end else if (sp_fail) begin
        sp_cnt_q <= dec_cnt(sp_cnt_q);
      end
      // safety-loop counter
      if (reload_all || day_tick) begin
        sl_cnt_q <= (o_lockout && mrst_pulse) ? sl_limit_q : sl_limit_act_q;
      end else if (i_loop_open) begin
        sl_cnt_q <= dec_cnt(sl_cnt_q);
      end
      // powered-time timer
      hour_tmr_q <= hour_tick ? 64'h0 : hour_tmr_q + 64'h1;
      if (hour_tick) begin
        day_h_q <= (day_h_q == 5'd23) ? 5'd0 : day_h_q + 5'd1;
        if (!(i_wr && i_addr == `RLRC_REG_LIVE_H)) begin
          live_h_q <= live_h_q + 32'h1;
        end
      end
      // operating hours run from first safety time to end of operation
      if (i_first_safety_time) begin
        running_q <= 1'b1;
      end else if (i_operation_end) begin
        running_q <= 1'b0;
      end
      run_tmr_q <= (!running_q || run_hour) ? 64'h0 : run_tmr_q + 64'h1;
      if (run_hour) begin
        oph_ro_q <= oph_ro_q + 32'h1;
        if (!(i_wr && i_addr == `RLRC_REG_OPH_ADJ)) begin
          oph_adj_q <= oph_adj_q + 32'h1;
        end
      end
      // every start cycle counts, aborted or not
      if (i_start_cycle) begin
        starts_ro_q <= starts_ro_q + 32'h1;
        if (!(i_wr && i_addr == `RLRC_REG_STARTS_ADJ)) begin
          starts_adj_q <= starts_adj_q + 32'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // error reporting, restart grant, lockout and program stop
  // ----------------------------------------------------------------------------
  reg [15:0] err_d;

  // priority: elapsed codes over the plain fault codes
  always @* begin
    err_d = `RLRC_ERR_NONE;
    if (sl_elapsed) begin
      err_d = `RLRC_ERR_LOOP_ELAPSED;
    end else if (sp_elapsed) begin
      err_d = `RLRC_ERR_SP_ELAPSED;
    end else if (nf_elapsed) begin
      err_d = `RLRC_ERR_NOFLAME_ELAPSED;
    end else if (i_loop_open) begin
      err_d = `RLRC_ERR_LOOP_OPEN;
    end else if (i_noflame_second) begin
      err_d = `RLRC_ERR_NOFLAME_2;
    end else if (i_noflame_first) begin
      err_d = `RLRC_ERR_NOFLAME_1;
    end else if (i_sp_loop) begin
      err_d = `RLRC_ERR_SP_LOOP;
    end else if (i_sp_light) begin
      err_d = `RLRC_ERR_SP_LIGHT;
    end else if (i_sp_air) begin
      err_d = `RLRC_ERR_SP_AIR;
    end else if (lf_timeout_q) begin
      err_d = `RLRC_ERR_LOWFIRE_TIME;
    end
  end

  // outputs held in flops
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_error_code <= `RLRC_ERR_NONE;
      o_error_valid <= 1'b0;
      o_restart <= 1'b0;
      o_lockout <= 1'b0;
      o_loop_relays_on <= 1'b0;
      o_alarm <= 1'b0;
      o_prog_stop_hold <= 1'b0;
      o_prog_stop_msg <= 1'b0;
    end else begin
      o_error_valid <= (err_d != `RLRC_ERR_NONE);
      if (err_d != `RLRC_ERR_NONE) begin
        o_error_code <= err_d;
      end
      // restart granted for a failure that does not elapse its counter
      o_restart <= ~lockout_d & ((nf_fail & ~nf_elapsed) | (sp_fail & ~sp_elapsed)
                   | (i_loop_open & ~sl_elapsed));
      o_lockout <= lockout_d;
      o_loop_relays_on <= ~lockout_d;
      o_alarm <= lockout_d;
      // hold while the selected phase is reached and the stop stays selected
      o_prog_stop_hold <= (stop_sel_q != 3'd0) && (i_phase == stop_phase(stop_sel_q));
      o_prog_stop_msg <= (stop_sel_q != 3'd0) && (i_phase == stop_phase(stop_sel_q));
    end
  end

  // ----------------------------------------------------------------------------
  // low-fire shutdown sequence
  // ----------------------------------------------------------------------------
  // run: heat wanted; drive: go to low fire; close: valves shut
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lf_state_q <= LF_RUN;
      lf_tick_q <= 32'h0;
      lf_ms_q <= 16'h0;
      lf_timeout_q <= 1'b0;
      o_drive_low_fire <= 1'b0;
      o_close_fuel <= 1'b0;
    end else begin
      lf_timeout_q <= 1'b0;
      case (lf_state_q)
        LF_RUN: begin
          o_close_fuel <= 1'b0;
          lf_tick_q <= 32'h0;
          lf_ms_q <= 16'h0;
          if (running_q && !i_heat_request) begin
            lf_state_q <= LF_DRIVE;
            o_drive_low_fire <= 1'b1;
          end
        end
        LF_DRIVE: begin
          lf_tick_q <= (lf_tick_q == LOWFIRE_TICK_CYCLES - 32'd1) ? 32'h0 : lf_tick_q + 32'h1;
          if (lf_tick_q == LOWFIRE_TICK_CYCLES - 32'd1) begin
            lf_ms_q <= lf_ms_q + 16'h1;
          end
          if (i_low_fire_reached || lf_ms_q >= lowfire_max_q) begin
            lf_timeout_q <= !i_low_fire_reached;
            lf_state_q <= LF_CLOSE;
            o_drive_low_fire <= 1'b0;
            o_close_fuel <= 1'b1;
          end
        end
        LF_CLOSE: begin
          if (i_heat_request) begin
            lf_state_q <= LF_RUN;
            o_close_fuel <= 1'b0;
          end
        end
        default: lf_state_q <= LF_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------------------------------------------
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `RLRC_REG_CTRL: o_rdata <= {29'h0, o_alarm, o_lockout, o_prog_stop_hold};
        `RLRC_REG_STAT: o_rdata <= {28'h0, o_close_fuel, o_drive_low_fire, running_q, o_restart};
        `RLRC_REG_SP_LIMIT: o_rdata <= {1'b0, sl_limit_act_q, 1'b0, sp_limit_act_q,
                                        1'b0, sl_limit_q, 1'b0, sp_limit_q};
        `RLRC_REG_LOWFIRE_MAX: o_rdata <= {16'h0, lowfire_max_q};
        `RLRC_REG_OPH_RO: o_rdata <= oph_ro_q;
        `RLRC_REG_OPH_ADJ: o_rdata <= oph_adj_q;
        `RLRC_REG_LIVE_H: o_rdata <= live_h_q;
        `RLRC_REG_STARTS_RO: o_rdata <= starts_ro_q;
        `RLRC_REG_STARTS_ADJ: o_rdata <= starts_adj_q;
        `RLRC_REG_ERROR: o_rdata <= {16'h0, o_error_code};
        `RLRC_REG_COUNTERS: o_rdata <= {11'h0, day_h_q, 1'b0, sl_cnt_q, 1'b0, sp_cnt_q};
        `RLRC_REG_STOP_SEL: o_rdata <= {25'h0, nf_cnt_q[3:0], stop_sel_q};
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule // rlrc_top
`default_nettype wire

/* File: bench/rlrc_seq_model.sv */
/* rlrc_seq_model.sv - far-side model: ratio control actuators that travel to
   low fire a fixed number of cycles after the block asks for it.
   Assumes the bench clock and the active-low power-up reset. */
`timescale 1ns/10ps
`default_nettype none
module rlrc_seq_model #(
  parameter int DELAY = 12
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_drive_low_fire,
  output logic o_low_fire_reached
);
  logic [7:0] travel_q;
  // actuator travel time, restarts whenever the request is withdrawn
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      travel_q <= 8'h00;
    end else if (!i_drive_low_fire) begin
      travel_q <= 8'h00;
    end else if (travel_q != DELAY[7:0]) begin
      travel_q <= travel_q + 8'h01;
    end
  end
  // position switch closes only once travel is complete
  assign o_low_fire_reached = (travel_q == DELAY[7:0]);
endmodule // rlrc_seq_model
`default_nettype wire

/* File: bench/rlrc_chk_sva.sv */
/* rlrc_chk_sva.sv - concurrent checks on the ports of rlrc_top.
   Assumes a bind into every rlrc_top instance, one clock domain. */
`timescale 1ns/10ps
`default_nettype none
`include "rlrc_defines.vh"
module rlrc_chk (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_manual_reset,
  input wire logic i_noflame_first,
  input wire logic i_sp_air,
  input wire logic i_loop_open,
  input wire logic i_noflame_second,
  input wire logic i_sp_light,
  input wire logic i_sp_loop,
  input wire logic i_heat_request,
  input wire logic [7:0] i_phase,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_restart,
  input wire logic o_lockout,
  input wire logic o_loop_relays_on,
  input wire logic o_alarm,
  input wire logic o_prog_stop_hold,
  input wire logic o_prog_stop_msg,
  input wire logic o_drive_low_fire,
  input wire logic o_close_fuel,
  input wire logic [15:0] o_error_code,
  input wire logic o_error_valid
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // lockout outputs and their release
  a_lock_outputs: assert property (o_lockout |-> o_alarm && !o_loop_relays_on)
    else $error("lockout without alarm or with loop relays on");
  a_lock_held: assert property ($fell(o_lockout) |-> $past(i_manual_reset, 1)
    || $past(i_manual_reset, 2) || $past(i_manual_reset, 3) || $past(i_manual_reset, 4))
    else $error("lockout left without manual reset");
  // restarts and error codes follow a failure pulse
  a_restart_cause: assert property (o_restart |-> $past(i_noflame_first || i_noflame_second
    || i_sp_air || i_sp_light || i_sp_loop || i_loop_open))
    else $error("restart without a failure");
  a_noflame_code: assert property (i_noflame_first && !o_lockout |=> o_error_valid
    && (o_error_code == `RLRC_ERR_NOFLAME_1 || o_error_code == `RLRC_ERR_NOFLAME_ELAPSED))
    else $error("wrong no-flame code");
  a_air_code: assert property (i_sp_air && !o_lockout |=> o_error_valid
    && (o_error_code == `RLRC_ERR_SP_AIR || o_error_code == `RLRC_ERR_SP_ELAPSED))
    else $error("wrong start prevention code");
  a_loop_code: assert property (i_loop_open && !o_lockout |=> o_error_valid
    && (o_error_code == `RLRC_ERR_LOOP_OPEN || o_error_code == `RLRC_ERR_LOOP_ELAPSED))
    else $error("wrong safety loop code");
  // program stop only at a listed phase, message only while held
  a_stop_phase: assert property (o_prog_stop_hold |-> $past(i_phase) inside {`RLRC_PH_30,
    `RLRC_PH_34, `RLRC_PH_38, `RLRC_PH_44, `RLRC_PH_52, `RLRC_PH_74, `RLRC_PH_78})
    else $error("stop at a phase not offered");
  a_stop_msg: assert property (o_prog_stop_msg |-> o_prog_stop_hold)
    else $error("stop message without stop");
  // low fire comes first, fuel closes afterwards
  a_low_fire_go: assert property ($fell(i_heat_request) && !o_lockout |-> ##[1:3] o_drive_low_fire)
    else $error("no low fire after heat request ended");
  a_fuel_after: assert property ($rose(o_close_fuel) |-> $past(o_drive_low_fire))
    else $error("fuel closed before low fire");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
  c_restart: cover property (o_restart);
  c_loop_elapsed: cover property (o_lockout && o_error_code == `RLRC_ERR_LOOP_ELAPSED);
  c_stop: cover property (o_prog_stop_msg);
  c_fuel: cover property ($rose(o_close_fuel));
endmodule // rlrc_chk
bind rlrc_top rlrc_chk i_rlrc_chk (.*);
`default_nettype wire

/* File: bench/tb_top.sv */
/* tb_top.sv - directed bench for rlrc_top: failure pulses, register port,
   program stop and low-fire shutdown. Assumes shortened hour and tick counts. */
`timescale 1ns/10ps
`default_nettype none
`include "rlrc_defines.vh"
module tb_top;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_manual_reset = 1'b0;
  logic i_manual_lockout = 1'b0;
  logic i_heat_request = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_phase = 8'h00;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [10:0] ev = 11'h000;
  logic i_noflame_first, i_noflame_second, i_operating_reached, i_controlled_shutdown;
  logic i_sp_air, i_sp_light, i_sp_loop, i_loop_open, i_start_cycle;
  logic i_first_safety_time, i_operation_end, i_low_fire_reached;
  logic [31:0] o_rdata;
  logic o_restart, o_lockout, o_loop_relays_on, o_alarm, o_prog_stop_hold;
  logic o_prog_stop_msg, o_drive_low_fire, o_close_fuel, o_error_valid;
  logic [15:0] o_error_code;
  int n_mismatch = 0;
  int compares = 0;
  int k;
  localparam logic [7:0] stop_ph [1:7] = '{`RLRC_PH_30, `RLRC_PH_34, `RLRC_PH_38,
    `RLRC_PH_44, `RLRC_PH_52, `RLRC_PH_74, `RLRC_PH_78};
  // event pulses: 0 nf1, 1 nf2, 2 oper, 3 shutdown, 4 air, 5 light, 6 sp loop,
  // 7 loop open, 8 start, 9 first safety time, 10 operation end
  assign {i_operation_end, i_first_safety_time, i_start_cycle, i_loop_open, i_sp_loop,
    i_sp_light, i_sp_air, i_controlled_shutdown, i_operating_reached, i_noflame_second,
    i_noflame_first} = ev;
  rlrc_top #(.HOUR_CYCLES(64'h64), .LOWFIRE_TICK_CYCLES(32'h4)) i_rlrc_top (.*);
  rlrc_seq_model #(.DELAY(12)) i_rlrc_seq_model (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_drive_low_fire(o_drive_low_fire), .o_low_fire_reached(i_low_fire_reached));
  // 100 MHz clock
  always #5 i_mclk = ~i_mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp, "read data");
  endtask
  task automatic evt(input int n);
    @(posedge i_mclk);
    ev[n] <= 1'b1;
    @(posedge i_mclk);
    ev <= 11'h000;
    #1;
  endtask
  // one failure pulse, then the code and the restart flag
  task automatic fail(input int n, input logic [15:0] code, input logic rs);
    evt(n);
    chk(32'(o_error_code), 32'(code), "error code");
    chk(32'({o_restart, o_lockout}), 32'({rs, ~rs}), "restart or lockout");
  endtask
  task automatic mrst();
    @(posedge i_mclk);
    i_manual_reset <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_manual_reset <= 1'b0;
    repeat (4) @(posedge i_mclk);
    #1 chk(32'({o_lockout, o_alarm, o_loop_relays_on}), 32'h1, "released");
  endtask
  task automatic mlock();
    @(posedge i_mclk);
    i_manual_lockout <= 1'b1;
    repeat (5) @(posedge i_mclk);
    i_manual_lockout <= 1'b0;
    #1 chk(32'(o_lockout), 32'h1, "manual lockout");
  endtask
  // burner run, heat request withdrawn, low fire then fuel closed
  task automatic run_stop(input logic [15:0] code);
    @(posedge i_mclk) i_heat_request <= 1'b1;
    evt(9);
    repeat (250) @(posedge i_mclk);
    i_heat_request <= 1'b0;
    #1;
    for (k = 0; k < 10 && o_drive_low_fire !== 1'b1; k++) begin
      #10;
    end
    chk(32'({o_drive_low_fire, o_close_fuel}), 32'h2, "low fire first");
    for (k = 0; k < 600 && o_close_fuel !== 1'b1; k++) begin
      #10;
    end
    chk(32'(o_close_fuel), 32'h1, "fuel closed");
    #10 chk(32'(o_error_code), 32'(code), "code after stop");
    evt(10);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog, about six times the expected run
  initial begin
    #200000;
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    #1 chk(32'({o_lockout, o_alarm, o_loop_relays_on}), 32'h1, "after reset");
    rd(4'h3, 32'h64);
    rd(4'hF, 32'h0);
    $display("test reset done");
    for (k = 0; k < 3; k++) begin
      fail(7, `RLRC_ERR_LOOP_OPEN, 1'b1);
    end
    repeat (2450) @(posedge i_mclk);
    for (k = 0; k < 3; k++) begin
      fail(7, `RLRC_ERR_LOOP_OPEN, 1'b1);
    end
    fail(7, `RLRC_ERR_LOOP_ELAPSED, 1'b0);
    chk(32'({o_lockout, o_alarm, o_loop_relays_on}), 32'h6, "lockout");
    mrst();
    $display("test safety loop done");
    fail(0, `RLRC_ERR_NOFLAME_1, 1'b1);
    fail(1, `RLRC_ERR_NOFLAME_2, 1'b1);
    evt(2);
    for (k = 0; k < 3; k++) begin
      fail(0, `RLRC_ERR_NOFLAME_1, 1'b1);
    end
    fail(0, `RLRC_ERR_NOFLAME_ELAPSED, 1'b0);
    mrst();
    $display("test no flame done");
    fail(4, `RLRC_ERR_SP_AIR, 1'b1);
    fail(5, `RLRC_ERR_SP_LIGHT, 1'b1);
    fail(6, `RLRC_ERR_SP_LOOP, 1'b1);
    fail(4, `RLRC_ERR_SP_ELAPSED, 1'b0);
    mrst();
    wr(4'h2, 32'h0300);
    fail(4, `RLRC_ERR_SP_AIR, 1'b1);
    mlock();
    mrst();
    fail(4, `RLRC_ERR_SP_ELAPSED, 1'b0);
    wr(4'h2, 32'h037F);
    mlock();
    mrst();
    for (k = 0; k < 5; k++) begin
      fail(4, `RLRC_ERR_SP_AIR, 1'b1);
    end
    $display("test start prevention done");
    for (int s = 1; s < 8; s++) begin
      wr(4'hB, 32'(s));
      @(posedge i_mclk);
      i_phase <= stop_ph[s];
      repeat (20) @(posedge i_mclk);
      #1 chk(32'({o_prog_stop_hold, o_prog_stop_msg}), 32'h3, "stop");
      @(posedge i_mclk);
      i_phase <= stop_ph[s] + 8'h01;
      repeat (3) @(posedge i_mclk);
      #1 chk(32'({o_prog_stop_hold, o_prog_stop_msg}), 32'h0, "no stop");
    end
    wr(4'hB, 32'h0);
    i_phase <= `RLRC_PH_30;
    repeat (3) @(posedge i_mclk);
    #1 chk(32'(o_prog_stop_hold), 32'h0, "stop off");
    $display("test program stop done");
    evt(8);
    evt(8);
    rd(4'h7, 32'h2);
    wr(4'h8, 32'h5);
    rd(4'h8, 32'h5);
    rd(4'h7, 32'h2);
    run_stop(`RLRC_ERR_SP_AIR);
    rd(4'h4, 32'h2);
    rd(4'h5, 32'h2);
    wr(4'h3, 32'h2);
    run_stop(`RLRC_ERR_LOWFIRE_TIME);
    $display("test counters and low fire done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
